//--- verilog/attribute_controller_regs.svh
// Port addresses, register indexes, field positions and reset values
`ifndef ATTRIBUTE_CONTROLLER_REGS_SVH
`define ATTRIBUTE_CONTROLLER_REGS_SVH

// Host I/O port addresses
`define AC_PORT_WRITE      16'h03C0
`define AC_PORT_READ       16'h03C1
`define AC_PORT_STAT_MONO  16'h03BA
`define AC_PORT_STAT_COLR  16'h03DA

// Indexed register numbers
`define AC_IDX_PAL_LAST    5'h0F
`define AC_IDX_MODE        5'h10
`define AC_IDX_BORDER      5'h11
`define AC_IDX_PLANE_EN    5'h12
`define AC_IDX_HSHIFT      5'h13
`define AC_IDX_COLSEL      5'h14
`define AC_IDX_MISC        5'h16
`define AC_IDX_MISC1       5'h17

// Index register fields and data masks
`define AC_INDEX_MASK      8'h3F
`define AC_INDEX_PSRC_BIT  5
`define AC_PALETTE_MASK    8'h3F
`define AC_NIBBLE_MASK     8'h0F

// Mode control bits
`define AC_MODE_SBSG_BIT   7
`define AC_MODE_HALF_BIT   6
`define AC_MODE_PANOFF_BIT 5
`define AC_MODE_BLINK_BIT  3
`define AC_MODE_LGR_BIT    2
`define AC_MODE_MONO_BIT   1
`define AC_MODE_GFX_BIT    0

// Line-graphics character range
`define AC_LGR_FIRST       8'hC0
`define AC_LGR_LAST        8'hDF

// Reset values
`define AC_RST_BYTE        8'h00
`define AC_RST_INDEX       8'h00

`endif

//--- verilog/attribute_controller_pkg.sv
// Types shared by the attribute controller design
package attribute_controller_pkg;
    typedef enum logic [1:0] {
        TOGGLE_INDEX = 2'h1,
        TOGGLE_DATA  = 2'h2
    } toggle_state_t;
    typedef logic [7:0] byte_t;
endpackage : attribute_controller_pkg

//--- verilog/attribute_controller.sv
// Attribute controller: host register port, pixel FIFO and attribute path
//
// How it works
// - Reading the input status one port forces the toggle to index state.
// - Every byte write to the attribute write port flips the toggle.
// - Reading the attribute write port returns the index register.
// - In index state a port write loads the index, toggle goes data.
// - With 16-bit I/O on, a word access to the port resets the toggle.
// - Reading the attribute read port returns the indexed register selected.
// - In data state a port write updates the selected register, toggle goes index.
// - Palette-source zero: host palette writes allowed, video shows border colour.
// - Palette-source one: palette writes blocked, pipeline reads the palette.
// - Index low five bits select the register; bits 7:6 reserved.
// - Four plane bits address one of 16 entries; six-bit value is output.
// - Palette entries hold six colour bits; top two reserved.
// - Mode bit 7 picks secondary blue/green from colour select or palette.
// - Mode bit 6 halves pixel rate: four pixels per character clock.
// - Mode bit 5 suppresses panning in the split-screen region.
// - Blink on: blinking pixels toggle palette bit 3, others use upper eight.
// - Blink off: palette address bit 3 comes straight from pixel data.
// - Line graphics: ninth dot copies eighth for codes C0-DF, else zero.
// - Line graphics off: the ninth dot takes the plane 3 bit.
// - Mode bit 1 selects monochrome or colour attribute handling.
// - Mode bit 0 selects graphics or text pixel treatment.
`timescale 1ns/10ps
`default_nettype none
`include "attribute_controller_regs.svh"

// Small FIFO with valid/ready on both sides
module pixel_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    // Clock, reset, enable
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Depth must be a power of two for pointer wrap
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("pixel_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    wire              push = in_valid_i && in_ready_o && ce_i;
    wire              pop  = out_valid_o && out_ready_i && ce_i;

    // Honest full and empty
    assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (count_ff != '0);
    assign out_data_o  = mem_ff[rd_ptr_ff];

    // Pointers and occupancy
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (pop)  rd_ptr_ff <= rd_ptr_ff + AW'(1);
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Storage needs no reset; the count hides stale words
    // Storage
    always_ff @(posedge clk_i) begin
        if (push) mem_ff[wr_ptr_ff] <= in_data_i;
    end
endmodule : pixel_fifo

module attribute_controller
    import attribute_controller_pkg::*;
#(
    parameter int FIFO_DEPTH = 4
) (
    // Clock, reset, enable
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    // Host I/O cycle
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_rd_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_word_i,
    input  wire logic [7:0]  io_wdata_i,
    output logic      [7:0]  io_rdata_o,
    // Controller-wide settings
    input  wire logic        colour_addr_sel_i,
    input  wire logic        io16_en_i,
    input  wire logic        mode256_i,
    input  wire logic        nine_dot_i,
    input  wire logic        split_i,
    input  wire logic        blink_phase_i,
    // Pixel stream in
    input  wire logic        pix_valid_i,
    output logic             pix_ready_o,
    input  wire logic [7:0]  pix_data_i,
    input  wire logic [7:0]  pix_char_i,
    input  wire logic        pix_dot_i,
    input  wire logic        pix_dot8_i,
    input  wire logic        pix_plane3_i,
    input  wire logic        pix_ninth_i,
    // Video out
    output logic             video_valid_o,
    input  wire logic        video_ready_i,
    output logic      [7:0]  video_o,
    // Status towards the rest of the controller
    output logic [3:0]       pan_shift_o,
    output logic             attr_mono_o,
    output logic             index_state_o
);
    localparam int PW = 20;

    generate
        if (FIFO_DEPTH < 2) begin : g_bad_param
            $error("attribute_controller: FIFO_DEPTH too small");
        end
    endgenerate

    // Reserved index and palette bits are stored as zero
    // Register state
    toggle_state_t toggle_ff;
    byte_t         index_ff;
    byte_t         palette_ff [16];
    byte_t         mode_ff;
    byte_t         border_ff;
    byte_t         plane_en_ff;
    byte_t         hshift_ff;
    byte_t         colsel_ff;
    byte_t         misc_ff;
    byte_t         misc1_ff;
    byte_t         rdata_ff;

    // With io16_en_i set, a word access on the write port resets the toggle and writes no register; a word read still returns the index
    // Port decode
    wire [15:0] stat_addr  = colour_addr_sel_i ? `AC_PORT_STAT_COLR : `AC_PORT_STAT_MONO;
    wire        stat_rd    = io_rd_i && (io_addr_i == stat_addr);
    wire        wport_hit  = (io_addr_i == `AC_PORT_WRITE);
    wire        wport_rd   = io_rd_i && wport_hit;
    wire        rport_rd   = io_rd_i && (io_addr_i == `AC_PORT_READ);
    wire        word_reset = io16_en_i && io_word_i && wport_hit && (io_rd_i || io_wr_i);
    wire        byte_wr    = io_wr_i && wport_hit && !word_reset;
    wire        idx_wr     = byte_wr && (toggle_ff == TOGGLE_INDEX);
    wire        dat_wr     = byte_wr && (toggle_ff == TOGGLE_DATA);
    wire [4:0]  sel        = index_ff[4:0];
    wire        pal_src    = index_ff[`AC_INDEX_PSRC_BIT];
    wire        sel_pal    = (sel <= `AC_IDX_PAL_LAST);
    wire        pal_wr     = dat_wr && sel_pal && !pal_src;

    // Status read and word access take priority over the flip
    // Next toggle state
    toggle_state_t nxt_toggle;
    always_comb begin
        nxt_toggle = toggle_ff;
        if (stat_rd || word_reset) nxt_toggle = TOGGLE_INDEX;
        else if (idx_wr)           nxt_toggle = TOGGLE_DATA;
        else if (dat_wr)           nxt_toggle = TOGGLE_INDEX;
    end

    // Index 15 hex has no register behind it and reads zero
    // Selected indexed register for reads
    byte_t sel_val;
    always_comb begin
        sel_val = `AC_RST_BYTE;
        unique case (sel)
            `AC_IDX_MODE:     sel_val = mode_ff;
            `AC_IDX_BORDER:   sel_val = border_ff;
            `AC_IDX_PLANE_EN: sel_val = plane_en_ff;
            `AC_IDX_HSHIFT:   sel_val = hshift_ff;
            `AC_IDX_COLSEL:   sel_val = colsel_ff;
            `AC_IDX_MISC:     sel_val = misc_ff;
            `AC_IDX_MISC1:    sel_val = misc1_ff;
            default:          sel_val = sel_pal ? palette_ff[sel[3:0]] : `AC_RST_BYTE;
        endcase
    end

    wire byte_t nxt_rdata = wport_rd ? index_ff :
                            rport_rd ? sel_val  : `AC_RST_BYTE;

    // Toggle, index and read data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            toggle_ff <= TOGGLE_INDEX;
            index_ff  <= `AC_RST_INDEX;
            rdata_ff  <= `AC_RST_BYTE;
        end else if (ce_i) begin
            toggle_ff <= nxt_toggle;
            rdata_ff  <= nxt_rdata;
            if (idx_wr) index_ff <= io_wdata_i & `AC_INDEX_MASK;
        end
    end

    // Writes to index 15 hex match no register and vanish
    // Control registers written in data state
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_ff     <= `AC_RST_BYTE;
            border_ff   <= `AC_RST_BYTE;
            plane_en_ff <= `AC_RST_BYTE;
            hshift_ff   <= `AC_RST_BYTE;
            colsel_ff   <= `AC_RST_BYTE;
            misc_ff     <= `AC_RST_BYTE;
            misc1_ff    <= `AC_RST_BYTE;
        end else if (ce_i && dat_wr) begin
            if (sel == `AC_IDX_MODE)     mode_ff     <= io_wdata_i;
            if (sel == `AC_IDX_BORDER)   border_ff   <= io_wdata_i;
            if (sel == `AC_IDX_PLANE_EN) plane_en_ff <= io_wdata_i;
            if (sel == `AC_IDX_HSHIFT)   hshift_ff   <= io_wdata_i;
            if (sel == `AC_IDX_COLSEL)   colsel_ff   <= io_wdata_i;
            if (sel == `AC_IDX_MISC)     misc_ff     <= io_wdata_i;
            if (sel == `AC_IDX_MISC1)    misc1_ff    <= io_wdata_i;
        end
    end

    // Host writes are dropped while the pipeline owns the palette
    // Palette entries, one per generate slot
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_pal
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    palette_ff[gi] <= `AC_RST_BYTE;
                end else if (ce_i && pal_wr && sel[3:0] == 4'(gi)) begin
                    palette_ff[gi] <= io_wdata_i & `AC_PALETTE_MASK;
                end
            end
        end
    endgenerate

    // Absorbs sink stalls of up to FIFO_DEPTH pixels; a longer stall drops pix_ready_o
    // Pixel FIFO in the data path
    wire [PW-1:0] fifo_in = {pix_data_i, pix_char_i, pix_dot_i, pix_dot8_i,
                             pix_plane3_i, pix_ninth_i};
    wire [PW-1:0] fifo_out;
    wire          fifo_valid;
    wire          fifo_pop;

    pixel_fifo #(
        .WIDTH (PW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .in_valid_i  (pix_valid_i),
        .in_ready_o  (pix_ready_o),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_out)
    );

    // Unpacked FIFO word
    wire [7:0] q_data   = fifo_out[19:12];
    wire [7:0] q_char   = fifo_out[11:4];
    wire       q_dot    = fifo_out[3];
    wire       q_dot8   = fifo_out[2];
    wire       q_plane3 = fifo_out[1];
    wire       q_ninth  = fifo_out[0];

    // Mode control decode
    wire gfx      = mode_ff[`AC_MODE_GFX_BIT];
    wire mono     = mode_ff[`AC_MODE_MONO_BIT];
    wire lgr      = mode_ff[`AC_MODE_LGR_BIT];
    wire blink_en = mode_ff[`AC_MODE_BLINK_BIT];
    wire half     = mode_ff[`AC_MODE_HALF_BIT];
    wire sbsg_sel = mode_ff[`AC_MODE_SBSG_BIT];

    // Ninth-dot and text dot selection
    wire lgr_code  = (q_char >= `AC_LGR_FIRST) && (q_char <= `AC_LGR_LAST);
    wire ninth_dot = lgr ? (lgr_code & q_dot8) : q_plane3;
    wire text_dot  = (nine_dot_i && q_ninth) ? ninth_dot : q_dot;

    // Palette address: text picks fore/background, graphics uses planes
    wire [3:0] txt_idx   = text_dot ? q_data[3:0] : q_data[7:4];
    wire [3:0] raw_idx   = gfx ? (q_data[3:0] & plane_en_ff[3:0]) : txt_idx;
    wire       blinks    = gfx ? raw_idx[3] : q_data[7];
    wire       blink_a3  = blinks ? blink_phase_i : 1'b1;
    wire       addr3     = blink_en ? blink_a3 : raw_idx[3];
    wire [3:0] pal_addr  = {addr3, raw_idx[2:0]};
    wire [7:0] pal_val   = palette_ff[pal_addr];
    wire [1:0] sec_gb    = sbsg_sel ? colsel_ff[1:0] : pal_val[5:4];
    wire [7:0] plane_pix = {colsel_ff[3:2], sec_gb, pal_val[3:0]};
    wire [7:0] lut_pix   = mode256_i ? q_data : plane_pix;
    wire [7:0] nxt_video = pal_src ? lut_pix : border_ff;

    // A repeated pixel holds the FIFO, so input runs at half rate
    // Output slot and pixel doubling for half rate
    logic       out_valid_ff;
    logic [7:0] video_ff;
    logic       repeat_ff;
    wire        out_take = video_ready_i || !out_valid_ff;
    wire        rep_due  = half && !repeat_ff && out_valid_ff;
    assign fifo_pop = out_take && !rep_due;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_ff <= 1'b0;
            video_ff     <= `AC_RST_BYTE;
            repeat_ff    <= 1'b0;
        end else if (ce_i && out_take) begin
            if (rep_due) begin
                repeat_ff    <= 1'b1;
                out_valid_ff <= 1'b1;
            end else begin
                repeat_ff    <= 1'b0;
                out_valid_ff <= fifo_valid;
                if (fifo_valid) video_ff <= nxt_video;
            end
        end
    end

    // Outputs
    assign io_rdata_o    = rdata_ff;
    assign video_valid_o = out_valid_ff;
    assign video_o       = video_ff;
    assign pan_shift_o   = (split_i && mode_ff[`AC_MODE_PANOFF_BIT]) ? 4'h0
                                                                     : hshift_ff[3:0];
    assign attr_mono_o   = mono;
    assign index_state_o = (toggle_ff == TOGGLE_INDEX);
endmodule : attribute_controller
`default_nettype wire

//--- dv/attribute_controller_checker.sv
// Port-level assertions for the attribute controller
`timescale 1ns/10ps
`default_nettype none
`include "attribute_controller_regs.svh"
module attribute_controller_checker (
    // Clock, reset, enable
    input wire logic        clk_i, resetn_i, ce_i,
    // Host cycle and settings
    input wire logic [15:0] io_addr_i,
    input wire logic        io_rd_i, io_wr_i, io_word_i, io16_en_i, colour_addr_sel_i, split_i,
    // Observed outputs
    input wire logic [7:0]  io_rdata_o, video_o,
    input wire logic        index_state_o, video_valid_o, video_ready_i, attr_mono_o,
    input wire logic [3:0]  pan_shift_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Decoded host accesses
    wire stat_rd  = ce_i && io_rd_i
                 && io_addr_i == (colour_addr_sel_i ? `AC_PORT_STAT_COLR : `AC_PORT_STAT_MONO);
    wire word_acc = ce_i && (io_rd_i || io_wr_i) && io16_en_i && io_word_i
                 && io_addr_i == `AC_PORT_WRITE;
    wire port_wr  = ce_i && io_wr_i && io_addr_i == `AC_PORT_WRITE && !word_acc;
    wire unm_rd   = ce_i && io_rd_i && io_addr_i != `AC_PORT_WRITE && io_addr_i != `AC_PORT_READ;
    property p_stat; stat_rd |=> index_state_o; endproperty
    a_stat: assert property (p_stat) else $error("status read kept data state");
    property p_flip; port_wr |=> index_state_o != $past(index_state_o); endproperty
    a_flip: assert property (p_flip) else $error("port write did not flip toggle");
    property p_word; word_acc |=> index_state_o; endproperty
    a_word: assert property (p_word) else $error("word access kept data state");
    property p_hold; !(ce_i && (io_rd_i || io_wr_i)) |=> $stable(index_state_o); endproperty
    a_hold: assert property (p_hold) else $error("toggle moved without access");
    property p_unm; unm_rd |=> io_rdata_o == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_rd0; ce_i && !io_rd_i |=> io_rdata_o == 8'h00; endproperty
    a_rd0: assert property (p_rd0) else $error("read data left standing");
    property p_vid; video_valid_o && !video_ready_i |=> video_valid_o && $stable(video_o);
    endproperty
    a_vid: assert property (p_vid) else $error("video dropped while stalled");
    property p_mono; $changed(attr_mono_o) |-> $past(io_wr_i); endproperty
    a_mono: assert property (p_mono) else $error("mono flag moved without write");
    property p_pan; $changed(pan_shift_o) |-> $past(io_wr_i) || $changed(split_i); endproperty
    a_pan: assert property (p_pan) else $error("pan moved without cause");
    c_stat: cover property (stat_rd);
    c_word: cover property (word_acc);
    c_wr:   cover property (port_wr ##2 port_wr);
    c_vid:  cover property (video_valid_o && video_ready_i);
endmodule : attribute_controller_checker
bind attribute_controller attribute_controller_checker u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_word_i(io_word_i), .io16_en_i(io16_en_i),
    .colour_addr_sel_i(colour_addr_sel_i), .split_i(split_i), .io_rdata_o(io_rdata_o),
    .video_o(video_o), .index_state_o(index_state_o), .video_valid_o(video_valid_o),
    .video_ready_i(video_ready_i), .attr_mono_o(attr_mono_o), .pan_shift_o(pan_shift_o));
`default_nettype wire

//--- dv/io_host_model.sv
// Host processor model issuing one-cycle I/O reads and writes
`timescale 1ns/10ps
`default_nettype none
module io_host_model (
    // Clock
    input  wire logic        clk_i,
    // I/O cycle
    output var logic  [15:0] io_addr_o,
    output var logic         io_rd_o, io_wr_o, io_word_o,
    output var logic  [7:0]  io_wdata_o,
    input  wire logic [7:0]  io_rdata_i
);
    initial begin
        {io_addr_o, io_rd_o, io_wr_o, io_word_o, io_wdata_o} = '0;
    end
    // One write strobe; idle address and data show the inverse afterwards
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic w);
        @(posedge clk_i);
        {io_addr_o, io_wdata_o, io_word_o, io_wr_o} <= {a, d, w, 1'b1};
        @(posedge clk_i);
        {io_addr_o, io_wdata_o, io_word_o, io_wr_o} <= {~a, ~d, 2'b00};
    endtask : wr
    // One read strobe; data taken once the registered answer has landed
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_i);
        {io_addr_o, io_rd_o} <= {a, 1'b1};
        @(posedge clk_i);
        {io_addr_o, io_rd_o} <= {~a, 1'b0};
        #1 d = io_rdata_i;
    endtask : rd
endmodule : io_host_model
`default_nettype wire

//--- dv/tb_top.sv
// Self-checking bench: register port and pixel path against a behavioural model
`timescale 1ns/10ps
`default_nettype none
`include "attribute_controller_regs.svh"
module tb_top;
    import attribute_controller_pkg::*;
    logic clk_i = 0, resetn_i = 0, ce_i = 1, io_rd_i, io_wr_i, io_word_i, colour_addr_sel_i = 0;
    logic io16_en_i = 0, mode256_i = 0, nine_dot_i = 0, split_i = 0, blink_phase_i = 0;
    logic pix_valid_i = 0, pix_dot_i = 0, pix_dot8_i = 0, pix_plane3_i = 0, pix_ninth_i = 0;
    logic video_ready_i = 0, pix_ready_o, video_valid_o, attr_mono_o, index_state_o;
    logic [15:0] io_addr_i;
    logic [7:0]  io_wdata_i, io_rdata_o, video_o, pix_data_i = 0, pix_char_i = 0, rv;
    logic [3:0]  pan_shift_o;
    byte_t mreg [0:31];
    byte_t mindex = 8'h00, exp_q [$];
    logic  psrc = 0, go = 0, stall = 0;
    int    mismatches = 0, check_count = 0, cycles = 0, taken = 0;
    initial forever #2 clk_i = ~clk_i;
    attribute_controller dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_word_i(io_word_i),
        .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .colour_addr_sel_i(colour_addr_sel_i),
        .io16_en_i(io16_en_i), .mode256_i(mode256_i), .nine_dot_i(nine_dot_i), .split_i(split_i),
        .blink_phase_i(blink_phase_i), .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o),
        .pix_data_i(pix_data_i), .pix_char_i(pix_char_i), .pix_dot_i(pix_dot_i),
        .pix_dot8_i(pix_dot8_i), .pix_plane3_i(pix_plane3_i), .pix_ninth_i(pix_ninth_i),
        .video_valid_o(video_valid_o), .video_ready_i(video_ready_i), .video_o(video_o),
        .pan_shift_o(pan_shift_o), .attr_mono_o(attr_mono_o), .index_state_o(index_state_o));
    io_host_model host (.clk_i(clk_i), .io_addr_o(io_addr_i), .io_rd_o(io_rd_i),
        .io_wr_o(io_wr_i), .io_word_o(io_word_i), .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    // Index then data, model updated alongside
    task automatic reg_wr(input logic [4:0] i, input logic [7:0] d);
        host.wr(`AC_PORT_WRITE, {2'b11, psrc, i}, 1'b0);
        host.wr(`AC_PORT_WRITE, d, 1'b0);
        mindex = {2'b00, psrc, i};
        if (!(i == 5'h15 || (i <= `AC_IDX_PAL_LAST && psrc))) mreg[i] = (i < 16) ? d & 8'h3F : d;
    endtask : reg_wr
    task automatic reg_chk(input logic [4:0] i);
        host.wr(`AC_PORT_WRITE, {2'b00, psrc, i}, 1'b0);
        #1 check("index_state_o", index_state_o, 8'h00);
        host.rd(`AC_PORT_READ, rv);
        check("indexed", rv, (i == 5'h15) ? 8'h00 : mreg[i]);
        host.rd(`AC_PORT_WRITE, rv);
        check("index", rv, {2'b00, psrc, i});
        // Status read puts the toggle back so the next index write lands
        host.rd(colour_addr_sel_i ? `AC_PORT_STAT_COLR : `AC_PORT_STAT_MONO, rv);
        check("index_state_o", index_state_o, 8'h01);
    endtask : reg_chk
    // Expected pixel from the model registers and the pixel's own inputs
    function automatic byte_t exp_pix(byte_t d, byte_t c, logic dot, logic d8, logic p3, logic nn);
        byte_t m, p;
        logic [3:0] ix;
        logic bl;
        m = mreg[16];
        if (!mindex[5]) return mreg[17];
        if (mode256_i) return d;
        if (m[0]) begin
            ix = d[3:0] & mreg[18][3:0];
            bl = d[3];
        end else begin
            if (nine_dot_i && nn) dot = m[2] ? ((c >= 8'hC0 && c <= 8'hDF) ? d8 : 1'b0) : p3;
            ix = dot ? d[3:0] : d[7:4];
            bl = d[7];
        end
        if (m[3]) ix[3] = bl ? blink_phase_i : 1'b1;
        p = mreg[ix];
        return {mreg[20][3:2], m[7] ? mreg[20][1:0] : p[5:4], p[3:0]};
    endfunction : exp_pix
    // Pixel source, video sink and scoreboard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            print_verdict();
        end
        if (pix_valid_i && pix_ready_o) begin
            taken++;
            repeat (mreg[16][6] ? 2 : 1)
                exp_q.push_back(exp_pix(pix_data_i, pix_char_i, pix_dot_i, pix_dot8_i,
                    pix_plane3_i, pix_ninth_i));
        end
        if (video_valid_o && video_ready_i)
            check("video_o", video_o, exp_q.size() ? exp_q.pop_front() : 8'hXX);
        if (!pix_valid_i || pix_ready_o) begin
            pix_valid_i <= go;
            {pix_data_i, pix_char_i} <= $urandom;
            {pix_dot_i, pix_dot8_i, pix_plane3_i, pix_ninth_i} <= $urandom;
        end
        video_ready_i <= !stall && ($urandom % 4 != 0);
    end
    initial begin
        for (int k = 0; k < 32; k++) mreg[k] = 8'h00;
        void'($urandom(26740));
        repeat (4) @(posedge clk_i);
        resetn_i <= 1;
        #1 check("index_state_o", index_state_o, 8'h01);
        check("io_rdata_o", io_rdata_o, 8'h00);
        for (int i = 0; i < 24; i++) reg_wr(i, $urandom);
        for (int i = 0; i < 24; i++) reg_chk(i);
        host.rd(16'h03C5, rv);
        check("unmapped", rv, 8'h00);
        for (int s = 0; s < 2; s++) begin
            colour_addr_sel_i <= s;
            host.wr(`AC_PORT_WRITE, 8'h10, 1'b0);
            host.rd(s ? `AC_PORT_STAT_MONO : `AC_PORT_STAT_COLR, rv);
            check("index_state_o", index_state_o, 8'h00);
            host.rd(s ? `AC_PORT_STAT_COLR : `AC_PORT_STAT_MONO, rv);
            check("index_state_o", index_state_o, 8'h01);
        end
        io16_en_i <= 1;
        host.wr(`AC_PORT_WRITE, 8'h11, 1'b0);
        host.wr(`AC_PORT_WRITE, 8'h5A, 1'b1);
        #1 check("index_state_o", index_state_o, 8'h01);
        io16_en_i <= 0;
        reg_chk(5'h11);
        psrc = 1;
        reg_wr(5'h03, ~mreg[3]);
        reg_chk(5'h03);
        for (int b = 0; b < 10; b++) begin
            psrc = (b != 0);
            rv = $urandom;
            {mode256_i, nine_dot_i, split_i, blink_phase_i} <= {rv[3] && b > 5, rv[2:0]};
            reg_wr(5'h12, $urandom | 8'h08);
            reg_wr(5'h13, $urandom);
            reg_wr(5'h14, $urandom);
            reg_wr(5'h10, $urandom & 8'hEF);
            #1 check("pan_shift_o", pan_shift_o, (split_i && mreg[16][5]) ? 0 : mreg[19] & 15);
            check("attr_mono_o", attr_mono_o, mreg[16][1]);
            stall = (b == 1);
            taken = 0;
            go = 1;
            repeat (200) if (taken < 16) @(posedge clk_i);
            if (b == 1) check("pix_ready_o", pix_ready_o, 8'h00);
            stall = 0;
            go = 0;
            repeat (300) if (exp_q.size() || video_valid_o) @(posedge clk_i);
            check("drained", exp_q.size(), 8'h00);
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
